// file: rtl/crs_pkg.sv
package crs_pkg;

    // register select codes on the software port
    localparam logic [3:0] CRS_SEL_DATA0 = 4'h0;
    localparam logic [3:0] CRS_SEL_DATA1 = 4'h1;
    localparam logic [3:0] CRS_SEL_DATA2 = 4'h2;
    localparam logic [3:0] CRS_SEL_DATA3 = 4'h3;
    localparam logic [3:0] CRS_SEL_ADDR0 = 4'h4;
    localparam logic [3:0] CRS_SEL_ADDR1 = 4'h5;
    localparam logic [3:0] CRS_SEL_FRAME = 4'h6;
    localparam logic [3:0] CRS_SEL_PC = 4'h7;
    localparam logic [3:0] CRS_SEL_VTB = 4'h8;
    localparam logic [3:0] CRS_SEL_USP = 4'h9;
    localparam logic [3:0] CRS_SEL_ISP = 4'ha;
    localparam logic [3:0] CRS_SEL_SB = 4'hb;
    localparam logic [3:0] CRS_SEL_FLAG = 4'hc;

    // number of banked registers per bank
    localparam int CRS_BANK_REGS = 7;

    // flag word bit positions
    localparam int CRS_FLG_CARRY = 0;
    localparam int CRS_FLG_DEBUG = 1;
    localparam int CRS_FLG_ZERO = 2;
    localparam int CRS_FLG_SIGN = 3;
    localparam int CRS_FLG_BANK = 4;
    localparam int CRS_FLG_OVF = 5;
    localparam int CRS_FLG_IEN = 6;
    localparam int CRS_FLG_USTK = 7;
    localparam int CRS_FLG_IPL_LO = 12;

    // implemented flag bits: 0..7 and 12..14
    localparam logic [15:0] CRS_FLG_MASK = 16'h70ff;

    // reset values
    localparam logic [15:0] CRS_RST_WORD = 16'h0000;
    localparam logic [19:0] CRS_RST_PC = 20'h00000;
    localparam logic [15:0] CRS_RST_FLAG = 16'h0000;

    // software interrupt vectors below this switch stacks
    localparam logic [5:0] CRS_SWI_STACK_LIMIT = 6'h20;

    // byte lane select for the datapath write port
    typedef enum logic [2:0] {
        CRS_LANE_WORD = 3'b001,
        CRS_LANE_LOW = 3'b010,
        CRS_LANE_HIGH = 3'b100
    } crs_lane_type;

endpackage

// file: rtl/crs_bank.sv
`timescale 1ns/1ps
// one bank of the seven banked 16-bit registers
module crs_bank
    import crs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // write port
    input wire logic wr_en_i,
    input wire logic [2:0] wr_idx_i,
    input wire logic [15:0] wr_mask_i,
    input wire logic [15:0] wr_data_i,
    // all registers out, flattened
    output logic [16*CRS_BANK_REGS-1:0] regs_o
);
    // register storage for this bank
    logic [15:0] bank_reg [CRS_BANK_REGS];

    // masked write keeps the untouched byte half
    always_ff @(posedge clk_sys_i) begin
        for (int i = 0; i < CRS_BANK_REGS; i++) begin
            if (reset_i) begin
                bank_reg[i] <= CRS_RST_WORD;
            end else if (wr_en_i && wr_idx_i == 3'(i)) begin
                bank_reg[i] <= (bank_reg[i] & ~wr_mask_i) | (wr_data_i & wr_mask_i);
            end
        end
    end

    // flatten for the read side
    always_comb begin
        for (int i = 0; i < CRS_BANK_REGS; i++) begin
            regs_o[16*i +: 16] = bank_reg[i];
        end
    end
endmodule

// file: rtl/crs_regset.sv
`timescale 1ns/1ps
// Operation
// - thirteen registers, seven duplicated in banks
// - four 16-bit data registers
// - data 0/1 byte halves written independently
// - data 2:0 and 3:1 form 32-bit pairs
// - address registers also serve as data
// - address 1:0 form 32-bit address
// - banked 16-bit frame base register
// - 20-bit program counter
// - 20-bit vector table base
// - stack select bit 7 picks stack pointer
// - interrupt or low soft vector clears stack select
// - 16-bit static base register
// - flag word holds eleven functional bits
// - bit 0 captures carry from alu
// - debug bit raises single step request
// - bit 2 zero result flag
// - bit 3 negative result flag
// - bit 4 selects register bank
// - bit 5 overflow flag
// - bit 6 enables interrupts, cleared on ack
// - accept interrupt above priority level only
// - bits 8 to 11 reserved
// - bit 15 reserved
module crs_regset
    import crs_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic reset_i,
    // software register port
    input wire logic [3:0] sw_addr_i,
    input wire logic [19:0] sw_wdata_i,
    input wire logic sw_wr_i,
    input wire logic sw_rd_i,
    output logic [19:0] sw_rdata_o,
    // datapath register write
    input wire logic dp_wr_i,
    input wire logic [3:0] dp_sel_i,
    input wire logic [2:0] dp_lane_i,
    input wire logic [15:0] dp_wdata_i,
    // alu condition update
    input wire logic alu_upd_i,
    input wire logic alu_carry_i,
    input wire logic [15:0] alu_result_i,
    input wire logic alu_ovf_i,
    // program counter load
    input wire logic pc_load_i,
    input wire logic [19:0] pc_value_i,
    // interrupt events
    input wire logic instr_done_i,
    input wire logic hw_int_ack_i,
    input wire logic step_ack_i,
    input wire logic swi_exec_i,
    input wire logic [5:0] swi_vector_i,
    input wire logic irq_req_i,
    input wire logic [2:0] irq_level_i,
    // datapath read views
    output logic [15:0] data_reg_0_o,
    output logic [15:0] data_reg_1_o,
    output logic [7:0] data_reg_0_high_o,
    output logic [7:0] data_reg_0_low_o,
    output logic [7:0] data_reg_1_high_o,
    output logic [7:0] data_reg_1_low_o,
    output logic [31:0] data_pair_low_o,
    output logic [31:0] data_pair_high_o,
    output logic [15:0] addr_reg_0_o,
    output logic [15:0] addr_reg_1_o,
    output logic [31:0] addr_pair_o,
    output logic [15:0] frame_base_o,
    output logic [15:0] static_base_o,
    output logic [15:0] stack_ptr_o,
    output logic [19:0] program_counter_o,
    output logic [19:0] vector_table_base_o,
    output logic [15:0] flag_word_o,
    // interrupt decisions
    output logic step_int_o,
    output logic irq_accept_o
);

    // mask for a lane choice, used by datapath writes only; software writes take the word
    function automatic logic [15:0] lane_mask(input logic [2:0] lane);
        logic [15:0] m;
        m = 16'h0000;
        case (lane)
            CRS_LANE_WORD: m = 16'hffff;
            CRS_LANE_LOW: m = 16'h00ff;
            CRS_LANE_HIGH: m = 16'hff00;
            default: m = 16'h0000;
        endcase
        return m;
    endfunction

    // non-banked state
    logic [19:0] pc_reg;
    logic [19:0] vtb_reg;
    logic [15:0] usp_reg;
    logic [15:0] isp_reg;
    logic [15:0] sb_reg;
    logic [15:0] flag_reg;
    logic [15:0] flag_next;
    logic [19:0] rdata_wide_reg;

    // combined write port: software wins over datapath in one cycle
    wire logic wr_any = sw_wr_i | dp_wr_i;
    wire logic [3:0] wr_sel = sw_wr_i ? sw_addr_i : dp_sel_i;
    wire logic [15:0] wr_data = sw_wr_i ? sw_wdata_i[15:0] : dp_wdata_i;
    // byte lanes only exist for data 0 and 1; other targets take the word
    wire logic byte_ok = (wr_sel == CRS_SEL_DATA0) || (wr_sel == CRS_SEL_DATA1);
    wire logic [15:0] wr_mask = (sw_wr_i || !byte_ok) ? 16'hffff : lane_mask(dp_lane_i);

    // banked write decode
    wire logic banked_hit = wr_any && (wr_sel <= CRS_SEL_FRAME);
    wire logic bank_sel = flag_reg[CRS_FLG_BANK];
    wire logic bank0_wr = banked_hit && !bank_sel;
    wire logic bank1_wr = banked_hit && bank_sel;

    logic [16*CRS_BANK_REGS-1:0] bank0_regs;
    logic [16*CRS_BANK_REGS-1:0] bank1_regs;

    crs_bank u_bank0 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .wr_en_i(bank0_wr),
        .wr_idx_i(wr_sel[2:0]),
        .wr_mask_i(wr_mask),
        .wr_data_i(wr_data),
        .regs_o(bank0_regs)
    );
    crs_bank u_bank1 (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .wr_en_i(bank1_wr),
        .wr_idx_i(wr_sel[2:0]),
        .wr_mask_i(wr_mask),
        .wr_data_i(wr_data),
        .regs_o(bank1_regs)
    );

    wire logic [16*CRS_BANK_REGS-1:0] cur_regs = bank_sel ? bank1_regs : bank0_regs;

    assign data_reg_0_o = cur_regs[16*0 +: 16];
    assign data_reg_1_o = cur_regs[16*1 +: 16];
    // byte halves of data 0 and 1
    assign data_reg_0_high_o = data_reg_0_o[15:8];
    assign data_reg_0_low_o = data_reg_0_o[7:0];
    assign data_reg_1_high_o = data_reg_1_o[15:8];
    assign data_reg_1_low_o = data_reg_1_o[7:0];
    assign data_pair_low_o = {cur_regs[16*2 +: 16], data_reg_0_o};
    assign data_pair_high_o = {cur_regs[16*3 +: 16], data_reg_1_o};
    assign addr_reg_0_o = cur_regs[16*4 +: 16];
    assign addr_reg_1_o = cur_regs[16*5 +: 16];
    assign addr_pair_o = {addr_reg_1_o, addr_reg_0_o};
    assign frame_base_o = cur_regs[16*6 +: 16];
    assign static_base_o = sb_reg;
    assign stack_ptr_o = flag_reg[CRS_FLG_USTK] ? usp_reg : isp_reg;
    assign program_counter_o = pc_reg;
    assign vector_table_base_o = vtb_reg;
    assign flag_word_o = flag_reg;

    // single step request after each instruction
    assign step_int_o = flag_reg[CRS_FLG_DEBUG] && instr_done_i;
    assign irq_accept_o = irq_req_i && flag_reg[CRS_FLG_IEN]
                          && (irq_level_i > flag_reg[14:12]);

    // flat register write strobes
    wire logic flag_wr = wr_any && wr_sel == CRS_SEL_FLAG;
    wire logic swi_low = swi_exec_i && (swi_vector_i < CRS_SWI_STACK_LIMIT);

    // flag next value: write first, then hardware events on top
    always_comb begin
        flag_next = flag_reg;
        if (flag_wr) begin
            flag_next = wr_data & CRS_FLG_MASK;
        end
        if (alu_upd_i) begin
            flag_next[CRS_FLG_CARRY] = alu_carry_i;
            flag_next[CRS_FLG_ZERO] = (alu_result_i == 16'h0000);
            flag_next[CRS_FLG_SIGN] = alu_result_i[15];
            flag_next[CRS_FLG_OVF] = alu_ovf_i;
        end
        if (step_ack_i) begin
            flag_next[CRS_FLG_DEBUG] = 1'b0;
        end
        if (hw_int_ack_i || step_ack_i) begin
            flag_next[CRS_FLG_IEN] = 1'b0;
        end
        if (hw_int_ack_i || swi_low) begin
            flag_next[CRS_FLG_USTK] = 1'b0;
        end
    end

    // flag register; eleven live bits
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            flag_reg <= CRS_RST_FLAG;
        end else begin
            flag_reg <= flag_next & CRS_FLG_MASK;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            pc_reg <= CRS_RST_PC;
        end else if (wr_any && wr_sel == CRS_SEL_PC) begin
            pc_reg <= sw_wr_i ? sw_wdata_i : {4'h0, dp_wdata_i};
        end else if (pc_load_i) begin
            pc_reg <= pc_value_i;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            vtb_reg <= CRS_RST_PC;
        end else if (wr_any && wr_sel == CRS_SEL_VTB) begin
            vtb_reg <= sw_wr_i ? sw_wdata_i : {4'h0, dp_wdata_i};
        end
    end

    // stack pointers and static base
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            usp_reg <= CRS_RST_WORD;
            isp_reg <= CRS_RST_WORD;
            sb_reg <= CRS_RST_WORD;
        end else if (wr_any) begin
            if (wr_sel == CRS_SEL_USP) begin
                usp_reg <= wr_data;
            end
            if (wr_sel == CRS_SEL_ISP) begin
                isp_reg <= wr_data;
            end
            if (wr_sel == CRS_SEL_SB) begin
                sb_reg <= wr_data;
            end
        end
    end

    // read mux, registered so data appear one cycle after strobe
    logic [19:0] rd_mux;
    always_comb begin
        case (sw_addr_i)
            CRS_SEL_DATA0, CRS_SEL_DATA1, CRS_SEL_DATA2, CRS_SEL_DATA3,
            CRS_SEL_ADDR0, CRS_SEL_ADDR1, CRS_SEL_FRAME:
                rd_mux = {4'h0, cur_regs[16*sw_addr_i[2:0] +: 16]};
            CRS_SEL_PC: rd_mux = pc_reg;
            CRS_SEL_VTB: rd_mux = vtb_reg;
            CRS_SEL_USP: rd_mux = {4'h0, usp_reg};
            CRS_SEL_ISP: rd_mux = {4'h0, isp_reg};
            CRS_SEL_SB: rd_mux = {4'h0, sb_reg};
            CRS_SEL_FLAG: rd_mux = {4'h0, flag_reg};
            default: rd_mux = 20'h00000;
        endcase
    end

    // read data hold only in the cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            rdata_wide_reg <= 20'h00000;
        end else begin
            rdata_wide_reg <= sw_rd_i ? rd_mux : 20'h00000;
        end
    end
    assign sw_rdata_o = rdata_wide_reg;

    // guards on the flag word
    // reserved flag bits never set
    a_flag_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (flag_reg & ~CRS_FLG_MASK) == 16'h0000)
        else $error("reserved flag bit set");
    a_zero_flag_track: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        alu_upd_i && !flag_wr |=> flag_reg[CRS_FLG_ZERO] == ($past(alu_result_i) == 16'h0000))
        else $error("zero flag mismatch");
    a_sign_flag_track: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        alu_upd_i && !flag_wr |=> flag_reg[CRS_FLG_SIGN] == $past(alu_result_i[15]))
        else $error("sign flag mismatch");
    // carry and overflow follow the alu even over a software write
    a_carry_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        alu_upd_i |=> flag_reg[CRS_FLG_CARRY] == $past(alu_carry_i))
        else $error("carry flag mismatch");
    a_ovf_capture: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        alu_upd_i |=> flag_reg[CRS_FLG_OVF] == $past(alu_ovf_i))
        else $error("overflow flag mismatch");

    // guards on interrupt side effects
    a_stack_sel_clear: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        hw_int_ack_i || swi_low |=> !flag_reg[CRS_FLG_USTK])
        else $error("stack select not cleared");
    a_ien_clear_ack: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        hw_int_ack_i |=> !flag_reg[CRS_FLG_IEN])
        else $error("enable not cleared on ack");
    a_debug_clear_ack: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        step_ack_i |=> !flag_reg[CRS_FLG_DEBUG])
        else $error("debug flag not cleared on ack");
    a_irq_level_gate: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        irq_accept_o |-> irq_level_i > flag_word_o[14:12])
        else $error("interrupt accepted at low level");
    // a write to the selected pointer shows on the stack output in the next cycle
    a_stack_ptr_pick: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        sw_wr_i && (sw_addr_i == CRS_SEL_USP || sw_addr_i == CRS_SEL_ISP)
        && (sw_addr_i == CRS_SEL_USP) == flag_word_o[CRS_FLG_USTK]
        && !hw_int_ack_i && !swi_low
        |=> stack_ptr_o == $past(sw_wdata_i[15:0]))
        else $error("wrong stack pointer");

    // guards on register storage
    a_pc_load_take: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        pc_load_i && !(wr_any && wr_sel == CRS_SEL_PC)
        |=> program_counter_o == $past(pc_value_i))
        else $error("pc load lost");
    a_byte_write_keep: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        dp_wr_i && !sw_wr_i && dp_sel_i == CRS_SEL_DATA0 && dp_lane_i == CRS_LANE_LOW
        && !flag_wr && !alu_upd_i
        |=> data_reg_0_high_o == $past(data_reg_0_high_o))
        else $error("high byte disturbed");
    // the other bank held still, so its old word must show right away
    a_bank_switch_now: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $changed(flag_reg[CRS_FLG_BANK]) |-> data_reg_0_o == (flag_reg[CRS_FLG_BANK]
        ? $past(bank1_regs[15:0]) : $past(bank0_regs[15:0])))
        else $error("stale bank after switch");

    // main scenarios
    c_bank_switch: cover property (@(posedge clk_sys_i) $rose(flag_reg[CRS_FLG_BANK]));
    c_irq_accept: cover property (@(posedge clk_sys_i) irq_accept_o);
    c_step_int: cover property (@(posedge clk_sys_i) step_int_o);
    c_swi_low: cover property (@(posedge clk_sys_i) swi_low && flag_reg[CRS_FLG_USTK]);
    c_byte_write: cover property (@(posedge clk_sys_i) dp_wr_i && dp_lane_i != CRS_LANE_WORD);

endmodule

// file: test/tb.sv
`timescale 1ns/1ps
// self-checking bench for the register set, driven through its own ports
module tb;
    import crs_pkg::*;

    // compare one design value with its expectation, case equality
    `define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end

    // clock, reset and bench counters
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    // software port
    logic [3:0] sw_addr_i = 4'h0;
    logic [19:0] sw_wdata_i = 20'h00000;
    logic sw_wr_i = 1'b0;
    logic sw_rd_i = 1'b0;
    logic [19:0] sw_rdata_o;
    // datapath write, alu, pc and interrupt inputs
    logic dp_wr_i = 1'b0;
    logic [3:0] dp_sel_i = 4'h0;
    logic [2:0] dp_lane_i = 3'h1;
    logic [15:0] dp_wdata_i = 16'h0000;
    logic alu_carry_i = 1'b0;
    logic [15:0] alu_result_i = 16'h0000;
    logic alu_ovf_i = 1'b0;
    logic [19:0] pc_value_i = 20'h00000;
    logic [5:0] swi_vector_i = 6'h00;
    logic irq_req_i = 1'b0;
    logic [2:0] irq_level_i = 3'h0;
    // one-cycle events: done, hw ack, step ack, swi, alu update, pc load
    logic [5:0] ev = 6'h00;
    // datapath views
    logic [15:0] d0, d1, a0, a1, fb, sb, sp, flag_word;
    logic [7:0] d0h, d0l, d1h, d1l;
    logic [31:0] pl, ph, ap;
    logic [19:0] pc, vtb;
    logic step_int_o, irq_accept_o;
    logic [19:0] rd, exp_v;

    always #2.5 clk_sys_i = ~clk_sys_i;

    crs_regset u_dut (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i),
        .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
        .dp_wr_i(dp_wr_i), .dp_sel_i(dp_sel_i), .dp_lane_i(dp_lane_i),
        .dp_wdata_i(dp_wdata_i), .alu_upd_i(ev[4]), .alu_carry_i(alu_carry_i),
        .alu_result_i(alu_result_i), .alu_ovf_i(alu_ovf_i),
        .pc_load_i(ev[5]), .pc_value_i(pc_value_i), .instr_done_i(ev[0]),
        .hw_int_ack_i(ev[1]), .step_ack_i(ev[2]), .swi_exec_i(ev[3]),
        .swi_vector_i(swi_vector_i), .irq_req_i(irq_req_i), .irq_level_i(irq_level_i),
        .data_reg_0_o(d0), .data_reg_1_o(d1), .data_reg_0_high_o(d0h),
        .data_reg_0_low_o(d0l), .data_reg_1_high_o(d1h), .data_reg_1_low_o(d1l),
        .data_pair_low_o(pl), .data_pair_high_o(ph), .addr_reg_0_o(a0),
        .addr_reg_1_o(a1), .addr_pair_o(ap), .frame_base_o(fb), .static_base_o(sb),
        .stack_ptr_o(sp), .program_counter_o(pc), .vector_table_base_o(vtb),
        .flag_word_o(flag_word), .step_int_o(step_int_o), .irq_accept_o(irq_accept_o)
    );

    // one-cycle write strobe; #1 lets the edge's updates land before checks
    task automatic sw_write(input logic [3:0] a, input logic [19:0] v);
        @(posedge clk_sys_i);
        sw_wr_i <= 1'b1;
        sw_addr_i <= a;
        sw_wdata_i <= v;
        @(posedge clk_sys_i);
        sw_wr_i <= 1'b0;
        #1;
    endtask

    // read data stands only in the cycle after the strobe, then zero
    task automatic sw_read(input logic [3:0] a, output logic [19:0] v);
        @(posedge clk_sys_i);
        sw_rd_i <= 1'b1;
        sw_addr_i <= a;
        @(posedge clk_sys_i);
        sw_rd_i <= 1'b0;
        #1 v = sw_rdata_o;
        @(posedge clk_sys_i);
        #1 `CHK(sw_rdata_o, 20'h00000)
    endtask

    task automatic dp_write(input logic [3:0] s, input logic [2:0] l, input logic [15:0] v);
        @(posedge clk_sys_i);
        dp_wr_i <= 1'b1;
        dp_sel_i <= s;
        dp_lane_i <= l;
        dp_wdata_i <= v;
        @(posedge clk_sys_i);
        dp_wr_i <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int i);
        @(posedge clk_sys_i);
        ev[i] <= 1'b1;
        @(posedge clk_sys_i);
        ev <= 6'h00;
        #1;
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // hang guard, far above the about 135 cycles the tests need
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        #1 `CHK(flag_word, 16'h0000)
        `CHK(pc, 20'h00000)
        $display("test reset done");

        // every select written then read back; unmapped ones stay zero
        for (int s = 0; s < 16; s++) begin
            sw_write(4'(s), {12'hf5a, 4'h0, 4'(s)});
            sw_read(4'(s), rd);
            exp_v = {4'h0, 12'h5a0, 4'(s)};
            if (s == 7 || s == 8) exp_v = {12'hf5a, 4'h0, 4'(s)};
            if (s == 12) exp_v = 20'h0500c;
            if (s > 12) exp_v = 20'h00000;
            `CHK(rd, exp_v)
        end
        $display("test map done");

        // reserved flag bits ignore writes and read zero
        sw_write(CRS_SEL_FLAG, 20'hfffff);
        `CHK(flag_word, 16'h70ff)
        // bank switch takes effect at once
        sw_write(CRS_SEL_FLAG, 20'h00010);
        `CHK(d0, 16'h0000)
        sw_write(CRS_SEL_DATA0, 20'h02222);
        sw_write(CRS_SEL_FLAG, 20'h00000);
        `CHK(d0, 16'h5a00)
        sw_write(CRS_SEL_FLAG, 20'h00010);
        `CHK(d0, 16'h2222)
        sw_write(CRS_SEL_FLAG, 20'h00000);
        $display("test bank done");

        // byte halves, pairs and address views
        dp_write(CRS_SEL_DATA0, CRS_LANE_LOW, 16'h00ab);
        `CHK(d0, 16'h5aab)
        dp_write(CRS_SEL_DATA0, CRS_LANE_HIGH, 16'hcd00);
        `CHK(d0h, 8'hcd)
        `CHK(d0l, 8'hab)
        `CHK(d1h, 8'h5a)
        `CHK(d1l, 8'h01)
        `CHK(d1, 16'h5a01)
        `CHK(pl, 32'h5a02cdab)
        `CHK(ph, 32'h5a035a01)
        `CHK(ap, 32'h5a055a04)
        `CHK(a1, 16'h5a05)
        dp_write(CRS_SEL_ADDR0, CRS_LANE_WORD, 16'h1357);
        `CHK(a0, 16'h1357)
        `CHK(fb, 16'h5a06)
        `CHK(sb, 16'h5a0b)
        `CHK(vtb, 20'hf5a08)
        $display("test views done");

        // stack select and the events that clear it
        `CHK(sp, 16'h5a0a)
        sw_write(CRS_SEL_FLAG, 20'h000c0);
        `CHK(sp, 16'h5a09)
        pulse(1);
        `CHK(flag_word, 16'h0000)
        `CHK(sp, 16'h5a0a)
        sw_write(CRS_SEL_FLAG, 20'h00080);
        @(posedge clk_sys_i);
        swi_vector_i <= 6'h20;
        pulse(3);
        `CHK(flag_word, 16'h0080)
        @(posedge clk_sys_i);
        swi_vector_i <= 6'h1f;
        pulse(3);
        `CHK(flag_word, 16'h0000)
        $display("test stack done");

        // condition flags from the alu
        @(posedge clk_sys_i);
        alu_carry_i <= 1'b1;
        pulse(4);
        `CHK(flag_word, 16'h0005)
        @(posedge clk_sys_i);
        alu_carry_i <= 1'b0;
        alu_result_i <= 16'h8000;
        alu_ovf_i <= 1'b1;
        pulse(4);
        `CHK(flag_word, 16'h0028)
        $display("test alu done");

        // single step request and its acknowledge
        sw_write(CRS_SEL_FLAG, 20'h00042);
        `CHK(step_int_o, 1'b0)
        @(posedge clk_sys_i);
        ev[0] <= 1'b1;
        #1 `CHK(step_int_o, 1'b1)
        pulse(2);
        `CHK(flag_word, 16'h0000)
        // priority gate: level must exceed the processor level
        sw_write(CRS_SEL_FLAG, 20'h03040);
        @(posedge clk_sys_i);
        irq_req_i <= 1'b1;
        irq_level_i <= 3'h3;
        #1 `CHK(irq_accept_o, 1'b0)
        @(posedge clk_sys_i);
        irq_level_i <= 3'h4;
        #1 `CHK(irq_accept_o, 1'b1)
        sw_write(CRS_SEL_FLAG, 20'h03000);
        `CHK(irq_accept_o, 1'b0)
        $display("test interrupt done");

        // program counter load from the datapath
        @(posedge clk_sys_i);
        pc_value_i <= 20'habcde;
        pulse(5);
        `CHK(pc, 20'habcde)
        // a datapath word write zero-extends into the counter
        dp_write(CRS_SEL_PC, CRS_LANE_WORD, 16'h1234);
        `CHK(pc, 20'h01234)
        $display("test pc done");
        print_verdict();
    end
endmodule
